// *** include/pira_pkg.sv ***
// Package for the process image register access block
package pira_pkg;
    // ****************************************
    // Control byte fields
    // ****************************************
    localparam int CTL_REG_BIT = 7;
    localparam int CTL_DIR_BIT = 6;
    localparam int CTL_NUM_MSB = 5;
    localparam int NUM_W = 6;
    localparam int REG_COUNT = 64;

    // ****************************************
    // Register numbers and values
    // ****************************************
    localparam logic [5:0] REG_FW_VERSION = 6'h09;
    localparam logic [5:0] REG_UNLOCK = 6'h1f;
    localparam logic [5:0] REG_FEATURE = 6'h20;
    localparam logic [15:0] UNLOCK_VALUE = 16'h1235;
    localparam logic [15:0] RELOCK_VALUE = 16'h0000;
    localparam logic [15:0] USER_RESET = 16'h0000;
    // Firmware version characters: arbitrary neutral value
    localparam logic [7:0] FW_CHAR_HI = 8'h31;
    localparam logic [7:0] FW_CHAR_LO = 8'h42;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Process image bytes, high byte first in both directions
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] data_hi;
        logic [7:0] data_lo;
    } pira_image_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ANSWER = 2'b10
    } pira_state_e;
endpackage : pira_pkg

// *** src/pira_core.sv ***
// Register access engine of the process image for a fieldbus I/O terminal
//
// Contract
// RL1: Control bit 7 set selects register mode; fields are only acted on while it is set.
// RL2: Control bit 6 set writes the selected register, clear reads it.
// RL3: Control bits 5..0 give the register number 0 to 63.
// RL4: A read is acknowledged with a status byte equal to the control byte.
// RL5: A write is acknowledged with the control byte with bit 6 cleared.
// RL6: The output data word is ignored during a read.
// RL7: The host places the new value in the output word together with a write control byte.
// RL8: The host treats the input data word after a write as invalid.
// RL9: A read returns the current contents of the addressed register.
// RL10: The data word travels high byte first, low byte second, both ways.
// RL11: User registers reject writes unless unlocked; register 31 is always writable.
// RL12: Writing the unlock value to register 31 lifts write protection.
// RL13: Writing any other value to register 31 restores write protection.
// RL14: Changed register contents take effect only after a restart.
// RL15: Register 9 returns the firmware version as two ASCII characters.
// RL16: Register 32 holds the feature word that sets terminal properties.
// RL17: The host unlocks, writes, reads back, relocks, waiting for each acknowledgement.
//
// Overview
// The host side presents a control byte and a two-byte output word on every
// cycle of the process image. This engine looks at them on each rising clock
// edge and answers with a status byte and a two-byte input word one cycle later.
//
// Request detection
// A request is taken on the first edge at which the register-mode bit is set and
// the control byte differs from the byte seen on the edge before. A byte that is
// held for many cycles is therefore answered once only; to repeat an identical
// request the host drops the register-mode bit for one cycle in between.
// The data bytes play no part in detection, so a host that changes only the
// output word while keeping the control byte gets no second write.
//
// Answer timing
// The status byte and data bytes are registered and appear one cycle after the
// taking edge. They stand until the next request is taken, or until the
// register-mode bit drops, after which all three bytes read zero.
// A write answer leaves the data bytes at whatever they held before; the host
// must not read meaning into them.
//
// Protection
// After reset the user registers are locked. Only the unlock register accepts
// a write while locked, and every write to it decides the lock afresh from the
// value written. The firmware version word is never writable.
// Refused writes are still acknowledged; the host sees the same status byte in
// both cases and must read back to learn whether a write landed.
//
// Restart
// The register store has no reset, so its contents survive a restart. The
// feature word is copied to its active copy on the first edge after reset
// is released and is otherwise left alone while the terminal runs.
// A register other than the firmware version word reads back as unknown until it is written.
//
// Ports
// STATUS_BYTE_O and the two data bytes are the registered answer. UNLOCKED_O
// shows the lock state and ACTIVE_FEATURE_O the feature word in effect; both
// come straight from flip-flops so the host side sees clean levels.
// Limitation: one request per control byte change; the engine never queues.
// Trade-off: change detection costs one byte of history but needs no
// handshake bit in the process image, which has none to spare.
module pira_core (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] CTL_BYTE_I,
    input wire logic [7:0] HOST_OUT_HI_I,
    input wire logic [7:0] HOST_OUT_LO_I,
    output logic [7:0] STATUS_BYTE_O,
    output logic [7:0] TERM_IN_HI_O,
    output logic [7:0] TERM_IN_LO_O,
    output logic [15:0] ACTIVE_FEATURE_O,
    output logic UNLOCKED_O
);
    // ****************************************
    // Request decode
    // ****************************************
    pira_pkg::pira_image_s req;
    pira_pkg::pira_image_s answer;
    pira_pkg::pira_image_s next_answer;
    pira_pkg::pira_state_e state;
    pira_pkg::pira_state_e next_state;
    logic [7:0] last_ctl;
    logic [15:0] regs [pira_pkg::REG_COUNT];
    logic unlocked;
    logic restart_seen;
    logic [15:0] active_feature;
    logic [pira_pkg::REG_COUNT-1:0] reg_known;
    logic chk_wr_valid;
    logic [5:0] chk_wr_num;
    logic [15:0] chk_wr_word;

    assign req = '{ctl: CTL_BYTE_I, data_hi: HOST_OUT_HI_I, data_lo: HOST_OUT_LO_I};

    wire reg_mode = req.ctl[pira_pkg::CTL_REG_BIT]; // RL1
    wire is_write = req.ctl[pira_pkg::CTL_DIR_BIT]; // RL2
    wire [5:0] reg_num = req.ctl[pira_pkg::CTL_NUM_MSB:0]; // RL3
    wire [15:0] wr_word = {req.data_hi, req.data_lo}; // RL10
    // A new request is a changed control byte; a held byte is answered once
    wire new_req = reg_mode && (req.ctl != last_ctl);
    wire do_write = new_req && is_write;
    wire do_read = new_req && !is_write;

    // Decoding used for write gating only; readback compares the number directly
    function automatic logic is_user_reg(input logic [5:0] num);
        is_user_reg = (num != pira_pkg::REG_FW_VERSION);
    endfunction : is_user_reg

    wire unlock_hit = do_write && (reg_num == pira_pkg::REG_UNLOCK);
    // Unlock register always writable; others only when unlocked
    wire write_ok = do_write && is_user_reg(reg_num) &&
                    (unlocked || reg_num == pira_pkg::REG_UNLOCK); // RL11
    wire [15:0] rd_word = (reg_num == pira_pkg::REG_FW_VERSION) ?
                          {pira_pkg::FW_CHAR_HI, pira_pkg::FW_CHAR_LO} : // RL15
                          regs[reg_num]; // RL9

    // ****************************************
    // Answer selection
    // ****************************************
    always_comb begin
        next_answer = answer;
        next_state = pira_pkg::ST_IDLE;
        if (do_read) begin
            // Output word deliberately unused here
            next_answer = '{ctl: req.ctl, data_hi: rd_word[15:8], data_lo: rd_word[7:0]}; // RL4 RL6 RL10
            next_state = pira_pkg::ST_ANSWER;
        end else if (do_write) begin
            // Data bytes keep stale values; host must not use them
            next_answer.ctl = req.ctl & ~(8'h01 << pira_pkg::CTL_DIR_BIT); // RL5 RL8
            next_state = pira_pkg::ST_ANSWER;
        end else if (!reg_mode) begin
            next_answer = '{ctl: pira_pkg::BYTE_ZERO, data_hi: pira_pkg::BYTE_ZERO,
                            data_lo: pira_pkg::BYTE_ZERO};
        end
    end

    // Status and data registers
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            answer <= '{ctl: 8'h00, data_hi: 8'h00, data_lo: 8'h00};
            state <= pira_pkg::ST_IDLE;
            last_ctl <= 8'h00;
        end else begin
            answer <= next_answer;
            state <= next_state;
            last_ctl <= req.ctl;
        end
    end

    // ****************************************
    // Register store and protection
    // ****************************************
    // Contents survive a soft reset so a restart can adopt them
    genvar gi;
    generate
        for (gi = 0; gi < pira_pkg::REG_COUNT; gi++) begin : g_regs
            always_ff @(posedge SYS_CLK_I) begin
                if (write_ok && reg_num == 6'(gi)) begin
                    regs[gi] <= wr_word; // RL7
                end
            end
        end
    endgenerate

    // Lock state; reset returns to protected mode
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            unlocked <= 1'b0;
        end else if (unlock_hit) begin
            unlocked <= (wr_word == pira_pkg::UNLOCK_VALUE); // RL12 RL13
        end
    end

    // Written marks; a word never written since reset is unknown, so checks pass over it
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            reg_known <= '0;
        end else if (write_ok) begin
            reg_known[reg_num] <= 1'b1;
        end
    end

    // Last accepted write, held one cycle so the store can be checked afterwards
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            chk_wr_valid <= 1'b0;
            chk_wr_num <= 6'h00;
            chk_wr_word <= 16'h0000;
        end else begin
            chk_wr_valid <= write_ok;
            chk_wr_num <= reg_num;
            chk_wr_word <= wr_word;
        end
    end

    // Feature settings are adopted only at restart, never on the fly
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            restart_seen <= 1'b1;
            active_feature <= pira_pkg::USER_RESET;
        end else begin
            restart_seen <= 1'b0;
            if (restart_seen) begin
                active_feature <= regs[pira_pkg::REG_FEATURE]; // RL14 RL16
            end
        end
    end

    assign STATUS_BYTE_O = answer.ctl;
    assign TERM_IN_HI_O = answer.data_hi;
    assign TERM_IN_LO_O = answer.data_lo;
    assign ACTIVE_FEATURE_O = active_feature;
    assign UNLOCKED_O = unlocked;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_write_req;
        do_write;
    endsequence
    sequence s_read_req;
        do_read;
    endsequence

    a_read_ack_echo: assert property (s_read_req |=> STATUS_BYTE_O == $past(CTL_BYTE_I)) // RL4
        else $error("Read acknowledge differs from control byte");
    a_write_ack_dir: assert property (s_write_req |=>
        STATUS_BYTE_O == ($past(CTL_BYTE_I) & 8'hbf)) // RL5
        else $error("Write acknowledge does not clear direction bit");
    a_fw_version_word: assert property (do_read && reg_num == pira_pkg::REG_FW_VERSION |=>
        {TERM_IN_HI_O, TERM_IN_LO_O} == {pira_pkg::FW_CHAR_HI, pira_pkg::FW_CHAR_LO}) // RL15
        else $error("Firmware version word wrong");
    a_unlock_key_set: assert property (unlock_hit && wr_word == pira_pkg::UNLOCK_VALUE |=>
        UNLOCKED_O) // RL12
        else $error("Unlock value did not unlock");
    a_relock_key: assert property (unlock_hit && wr_word != pira_pkg::UNLOCK_VALUE |=>
        !UNLOCKED_O) // RL13
        else $error("Other value did not relock");
    // Protection gating; a refused write must never reach the store
    sequence s_locked_write;
        !unlocked && do_write && (reg_num != pira_pkg::REG_UNLOCK);
    endsequence
    sequence s_unlock_write;
        unlock_hit;
    endsequence
    sequence s_held_req;
        reg_mode && (req.ctl == last_ctl);
    endsequence

    a_locked_no_write: assert property (s_locked_write |-> !write_ok) // RL11
        else $error("Protected register was written");
    a_unlock_always_ok: assert property (s_unlock_write |-> write_ok) // RL11
        else $error("Unlock register write refused");
    a_fw_never_written: assert property (do_write &&
        (reg_num == pira_pkg::REG_FW_VERSION) |-> !write_ok) // RL15
        else $error("Firmware version word accepted a write");
    a_read_no_store: assert property (s_read_req |-> !write_ok) // RL6
        else $error("Read request wrote the store");

    // Store contents one cycle after an accepted write
    a_write_lands: assert property (chk_wr_valid |-> regs[chk_wr_num] == chk_wr_word) // RL7
        else $error("Accepted write did not land");
    a_unlock_word_kept: assert property (s_unlock_write |=>
        regs[pira_pkg::REG_UNLOCK] == $past(wr_word)) // RL12
        else $error("Unlock register lost its value");

    // Lock state moves only on a write to the unlock register
    a_lock_only_key: assert property (!unlock_hit |=> $stable(UNLOCKED_O)) // RL13
        else $error("Lock state changed without a key write");
    a_read_keeps_lock: assert property (s_read_req |=> $stable(UNLOCKED_O)) // RL2
        else $error("Read request changed the lock state");

    // Register mode off or a held byte: nothing new is answered
    a_no_reg_mode_idle: assert property (!reg_mode |=> STATUS_BYTE_O == 8'h00) // RL1
        else $error("Answer given outside register mode");
    a_no_mode_data: assert property (!reg_mode |=>
        {TERM_IN_HI_O, TERM_IN_LO_O} == 16'h0000) // RL1
        else $error("Data shown outside register mode");
    a_held_no_action: assert property (s_held_req |=> $stable(STATUS_BYTE_O)) // RL1
        else $error("Held control byte answered twice");
    a_status_mode_bit: assert property (STATUS_BYTE_O != 8'h00 |-> STATUS_BYTE_O[7]) // RL1
        else $error("Status byte without register mode bit");

    // Feature word moves only at restart, and restart leaves the store locked
    a_feature_held: assert property (!restart_seen |=> $stable(ACTIVE_FEATURE_O)) // RL14
        else $error("Feature changed without restart");
    a_restart_locked: assert property (restart_seen |-> !UNLOCKED_O) // RL14
        else $error("Restart left the store unlocked");

    // Read data only from a defined word; never-written words read as unknown
    a_read_data_word: assert property (do_read && (reg_known[reg_num] ||
        reg_num == pira_pkg::REG_FW_VERSION) |=>
        {TERM_IN_HI_O, TERM_IN_LO_O} == $past(rd_word)) // RL9 RL6 RL10
        else $error("Read data wrong");
endmodule : pira_core

// *** tb/pira_host_model.sv ***
// Host side model: bus coupler relaying the control program's process image
module pira_host_model (
    input wire logic clk_i,
    output pira_pkg::pira_image_s image_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Request driver
    // ****************************************
    // A non-register cycle first, so even an identical request is seen as new
    task automatic send(input logic [7:0] ctl, input logic [15:0] word);
        @(posedge clk_i);
        image_o <= '0;
        @(posedge clk_i);
        image_o <= '{ctl: ctl, data_hi: word[15:8], data_lo: word[7:0]};
        // Held until the answer has stood one cycle; write answers carry no data
        repeat (2) @(posedge clk_i);
    endtask : send
    // Drops register mode so no held request is taken again after a reset
    task automatic idle;
        @(posedge clk_i);
        image_o <= '0;
    endtask : idle
    initial image_o = '0;
endmodule : pira_host_model

// *** tb/pira_core_bench.sv ***
// Self-checking bench for the process image register access engine
module pira_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pira_pkg::pira_image_s img;
    logic [7:0] st, hi, lo;
    logic [15:0] feat, act, r;
    logic unl;
    logic [15:0] mem [64];
    bit known [64];
    bit open, act_ok;
    int n_mismatch = 0;
    int total_checks = 0;
    // ****************************************
    // Clock, host and design
    // ****************************************
    always #5 clk = ~clk;
    pira_host_model pira_host_model_inst (.clk_i(clk), .image_o(img));
    pira_core pira_core_inst (.SYS_CLK_I(clk), .RST_I(rst), .CTL_BYTE_I(img.ctl),
        .HOST_OUT_HI_I(img.data_hi), .HOST_OUT_LO_I(img.data_lo), .STATUS_BYTE_O(st),
        .TERM_IN_HI_O(hi), .TERM_IN_LO_O(lo), .ACTIVE_FEATURE_O(feat), .UNLOCKED_O(unl));
    // ****************************************
    // Compare tasks and verdict
    // ****************************************
    task automatic chk_b(input string what, input logic [7:0] exp, input logic [7:0] got);
        chk_w(what, {8'h00, exp}, {8'h00, got});
    endtask : chk_b
    task automatic chk_w(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_w
    task automatic test_done;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    // One request, then the model's status, data, lock and feature are compared
    task automatic op(input logic [7:0] c, input logic [15:0] d);
        logic [5:0] n;
        n = c[5:0];
        pira_host_model_inst.send(c, d);
        #1;
        chk_b("status", c[6] ? (c & 8'hbf) : c, st);
        if (!c[6] && known[n]) chk_w("data", mem[n], {hi, lo});
        if (c[6] && (n == pira_pkg::REG_UNLOCK || (open && n != pira_pkg::REG_FW_VERSION))) begin
            mem[n] = d;
            known[n] = 1'b1;
        end
        if (c[6] && n == pira_pkg::REG_UNLOCK) open = (d === pira_pkg::UNLOCK_VALUE);
        chk_w("unlocked", {15'h0, open}, {15'h0, unl});
        if (act_ok) chk_w("feature", act, feat);
    endtask : op
    // Watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        n_mismatch++;
        test_done;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        r = 16'($urandom(80149));
        mem[9] = {pira_pkg::FW_CHAR_HI, pira_pkg::FW_CHAR_LO};
        known[9] = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        op(8'h89, 16'($urandom));
        op(8'he0, 16'($urandom));
        op(8'hdf, pira_pkg::UNLOCK_VALUE);
        op(8'he0, r);
        op(8'ha0, 16'($urandom));
        op(8'hc9, ~r);
        op(8'h89, r);
        op(8'hdf, pira_pkg::RELOCK_VALUE);
        op(8'he0, ~r);
        op(8'ha0, 16'($urandom));
        op(8'h9f, 16'($urandom));
        // Register mode off: an unlock word must have no effect
        pira_host_model_inst.send(8'h5f, pira_pkg::UNLOCK_VALUE);
        #1;
        chk_b("status", 8'h00, st);
        chk_w("unlocked", 16'h0000, {15'h0, unl});
        for (int i = 0; i < 24; i++) begin
            op({1'b1, 1'($urandom), 6'($urandom_range(0, 63))},
                ($urandom % 3 == 0) ? pira_pkg::UNLOCK_VALUE : 16'($urandom));
        end
        // Restart adopts the stored feature word and relocks
        pira_host_model_inst.idle;
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        open = 1'b0;
        act = mem[32];
        act_ok = known[32];
        op(8'ha0, 16'($urandom));
        test_done;
    end
endmodule : pira_core_bench
